/* adcwd_regs.svh */
// register indices, field positions and reset values of the result formatter
`ifndef ADCWD_REGS_SVH
`define ADCWD_REGS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define ADCWD_IDX_CFG 10'h0bc
`define ADCWD_IDX_RESL 10'h0be
`define ADCWD_IDX_RESH 10'h0bf
`define ADCWD_IDX_GTH 10'h0c4
`define ADCWD_IDX_GTL 10'h0c5
`define ADCWD_IDX_LTH 10'h0c6
`define ADCWD_IDX_LTL 10'h0c7
`define ADCWD_IDX_MODE 10'h0c8
`define ADCWD_IDX_CTL 10'h0e8

// ****************************************************************
// field positions
// ****************************************************************
`define ADCWD_CTL_ENABLE 7
`define ADCWD_CTL_DONE 5
`define ADCWD_CTL_BUSY 4
`define ADCWD_CTL_CM_HI 3
`define ADCWD_CTL_CM_LO 2
`define ADCWD_CTL_WIN 1
`define ADCWD_CTL_LJ 0
`define ADCWD_MODE_DIFF 0
`define ADCWD_CFG_SC_HI 7
`define ADCWD_CFG_SC_LO 3

// ****************************************************************
// reset values and timing counts
// ****************************************************************
`define ADCWD_RST_CFG 8'hf8
`define ADCWD_RST_CTL 8'h00
`define ADCWD_RST_MODE 8'h00
`define ADCWD_RST_RES 16'h0000
`define ADCWD_RST_GT 16'hffff
`define ADCWD_RST_LT 16'h0000
`define ADCWD_CONV_LAST 4'hf

`endif

/* adcwd_pkg.sv */
// types shared by the result formatter and window detector
package adcwd_pkg;

    typedef enum logic [1:0] {
        ADCWD_BUS_IDLE = 2'b01,
        ADCWD_BUS_ACK = 2'b10
    } adcwd_bus_t;

    typedef logic [15:0] adcwd_word_t;

endpackage : adcwd_pkg

/* adcwd_top.sv */
// converter result formatting and window compare behind an ahb-lite slave
//
// Operation
// (R1) right justify: high bits 7:2 copy bit 1
// (R2) right justify: high bits 1:0 hold top
// (R3) right justify: low byte holds lower eight
// (R4) left justify: high byte holds top eight
// (R5) left justify: low bits 7:6 hold bottom
// (R6) left justify: low bits 5:0 read zero
// (R7) sign extension only for differential readings
// (R8) unsigned single-ended, two's complement differential
// (R9) every result compared to limits automatically
// (R10) two limit words, written as byte pairs
// (R11) limit order selects inside or outside window
// (R12) lt above gt: flag inside window
// (R13) otherwise flag outside window
// (R14) differential compares are signed
// (R15) window evaluated only at conversion end
// (R16) conversion lasts sixteen converter clocks
// (R17) justify bit: 0 right, 1 left
// (R18) window flag sticky until software clears
// (R19) done flag set as busy falls
// (R20) compare uses justified sixteen-bit result word
`timescale 1ns/1ps
`default_nettype none
`include "adcwd_regs.svh"

module adcwd_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // converter core
    input wire logic [9:0] sar_code,
    output logic conversion_busy
);

    // ****************************************************************
    // helper functions
    // ****************************************************************
    function automatic adcwd_pkg::adcwd_word_t fmt_result(
        input logic [9:0] code,
        input logic lj,
        input logic diff
    );
        if (lj) begin
            fmt_result = {code, 6'h00}; // R4 R5 R6
        end else begin
            fmt_result = {{6{diff & code[9]}}, code}; // R1 R2 R3 R7 R8
        end
    endfunction : fmt_result

    function automatic logic below(
        input adcwd_pkg::adcwd_word_t a,
        input adcwd_pkg::adcwd_word_t b,
        input logic sgn
    );
        if (sgn) begin
            below = $signed(a) < $signed(b); // R14
        end else begin
            below = a < b;
        end
    endfunction : below

    // ****************************************************************
    // declarations
    // ****************************************************************
    adcwd_pkg::adcwd_bus_t bus_state_reg;
    logic [9:0] idx_reg;
    logic wr_pend_reg;
    logic [7:0] cfg_reg;
    logic [7:0] ctl_reg;
    logic [7:0] mode_reg;
    logic busy_reg;
    logic done_reg;
    logic win_reg;
    adcwd_pkg::adcwd_word_t res_reg;
    adcwd_pkg::adcwd_word_t gt_reg;
    adcwd_pkg::adcwd_word_t lt_reg;
    logic [4:0] presc_reg;
    logic [3:0] sarcnt_reg;
    logic [9:0] code_meta_reg;
    logic [9:0] code_sync_reg;
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;
    logic hresp_reg;

    logic addr_take;
    logic wr_en;
    logic [7:0] wd;
    logic start;
    logic tick;
    logic conv_end;
    logic diff;
    adcwd_pkg::adcwd_word_t res_next;
    logic lt_above;
    logic hit;
    logic [7:0] rd_val;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    assign addr_take = hsel && htrans[1] && hready;
    assign wr_en = (bus_state_reg == adcwd_pkg::ADCWD_BUS_ACK)
        && wr_pend_reg;
    assign wd = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_reg <= adcwd_pkg::ADCWD_BUS_IDLE;
            idx_reg <= 10'h000;
            wr_pend_reg <= 1'b0;
        end else begin
            unique case (bus_state_reg)
                adcwd_pkg::ADCWD_BUS_IDLE: begin
                    if (addr_take) begin
                        bus_state_reg <= adcwd_pkg::ADCWD_BUS_ACK;
                        idx_reg <= haddr[11:2];
                        wr_pend_reg <= hwrite;
                    end
                end
                adcwd_pkg::ADCWD_BUS_ACK: begin
                    bus_state_reg <= adcwd_pkg::ADCWD_BUS_IDLE;
                    wr_pend_reg <= 1'b0;
                end
            endcase
        end
    end

    // one wait state: hreadyout low in the cycle after the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_reg <= 1'b1;
            hrdata_reg <= 32'h0000_0000;
            hresp_reg <= 1'b0;
        end else begin
            hresp_reg <= 1'b0;
            if (bus_state_reg == adcwd_pkg::ADCWD_BUS_IDLE && addr_take) begin
                hreadyout_reg <= 1'b0;
            end else begin
                hreadyout_reg <= 1'b1;
            end
            if (bus_state_reg == adcwd_pkg::ADCWD_BUS_ACK) begin
                hrdata_reg <= {24'h00_0000, rd_val};
            end
        end
    end

    always_comb begin
        unique case (idx_reg)
            `ADCWD_IDX_CFG: rd_val = cfg_reg;
            `ADCWD_IDX_RESL: rd_val = res_reg[7:0];
            `ADCWD_IDX_RESH: rd_val = res_reg[15:8];
            `ADCWD_IDX_GTH: rd_val = gt_reg[15:8];
            `ADCWD_IDX_GTL: rd_val = gt_reg[7:0];
            `ADCWD_IDX_LTH: rd_val = lt_reg[15:8];
            `ADCWD_IDX_LTL: rd_val = lt_reg[7:0];
            `ADCWD_IDX_MODE: rd_val = mode_reg;
            `ADCWD_IDX_CTL: rd_val = {ctl_reg[7:6], done_reg, busy_reg,
                ctl_reg[3:2], win_reg, ctl_reg[0]};
            default: rd_val = 8'h00;
        endcase
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;

    // ****************************************************************
    // software registers
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_reg <= `ADCWD_RST_CFG;
            ctl_reg <= `ADCWD_RST_CTL;
            mode_reg <= `ADCWD_RST_MODE;
        end else if (wr_en) begin
            if (idx_reg == `ADCWD_IDX_CFG) begin
                cfg_reg <= wd;
            end
            if (idx_reg == `ADCWD_IDX_CTL) begin
                ctl_reg <= wd; // R17
            end
            if (idx_reg == `ADCWD_IDX_MODE) begin
                mode_reg <= wd;
            end
        end
    end

    // limit words, each loaded a byte at a time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gt_reg <= `ADCWD_RST_GT;
            lt_reg <= `ADCWD_RST_LT;
        end else if (wr_en) begin
            if (idx_reg == `ADCWD_IDX_GTH) begin
                gt_reg[15:8] <= wd; // R10
            end
            if (idx_reg == `ADCWD_IDX_GTL) begin
                gt_reg[7:0] <= wd; // R10
            end
            if (idx_reg == `ADCWD_IDX_LTH) begin
                lt_reg[15:8] <= wd; // R10
            end
            if (idx_reg == `ADCWD_IDX_LTL) begin
                lt_reg[7:0] <= wd; // R10
            end
        end
    end

    // ****************************************************************
    // converter sequencing
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            code_meta_reg <= 10'h000;
            code_sync_reg <= 10'h000;
        end else begin
            code_meta_reg <= sar_code;
            code_sync_reg <= code_meta_reg;
        end
    end

    // enable and start mode are taken from the byte being written
    assign start = wr_en && idx_reg == `ADCWD_IDX_CTL && wd[`ADCWD_CTL_BUSY]
        && wd[`ADCWD_CTL_ENABLE]
        && wd[`ADCWD_CTL_CM_HI:`ADCWD_CTL_CM_LO] == 2'b00
        && !busy_reg;
    assign tick = presc_reg == cfg_reg[`ADCWD_CFG_SC_HI:`ADCWD_CFG_SC_LO];
    assign conv_end = busy_reg && tick
        && sarcnt_reg == `ADCWD_CONV_LAST; // R16

    // converter clock is the system clock divided by field plus one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_reg <= 5'h00;
            sarcnt_reg <= 4'h0;
        end else if (!busy_reg || tick) begin
            presc_reg <= 5'h00;
            if (!busy_reg) begin
                sarcnt_reg <= 4'h0;
            end else begin
                sarcnt_reg <= sarcnt_reg + 4'h1; // R16
            end
        end else begin
            presc_reg <= presc_reg + 5'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_reg <= 1'b0;
        end else if (start) begin
            busy_reg <= 1'b1;
        end else if (conv_end) begin
            busy_reg <= 1'b0;
        end
    end

    assign conversion_busy = busy_reg;

    // ****************************************************************
    // result formatting and window compare
    // ****************************************************************
    assign diff = mode_reg[`ADCWD_MODE_DIFF];
    assign res_next = fmt_result(code_sync_reg,
        ctl_reg[`ADCWD_CTL_LJ], diff); // R17 R20
    assign lt_above = below(gt_reg, lt_reg, diff); // R11
    always_comb begin
        if (lt_above) begin
            hit = below(res_next, lt_reg, diff)
                && below(gt_reg, res_next, diff); // R12 R20
        end else begin
            hit = below(res_next, lt_reg, diff)
                || below(gt_reg, res_next, diff); // R13
        end
    end

    // hardware result update wins over a software write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_reg <= `ADCWD_RST_RES;
        end else if (conv_end) begin
            res_reg <= res_next; // R1 R2 R3 R4 R5 R6
        end else if (wr_en && idx_reg == `ADCWD_IDX_RESL) begin
            res_reg[7:0] <= wd;
        end else if (wr_en && idx_reg == `ADCWD_IDX_RESH) begin
            res_reg[15:8] <= wd;
        end
    end

    // sticky flags: a set in the cycle of a clear wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_reg <= 1'b0;
        end else if (conv_end) begin
            done_reg <= 1'b1; // R19
        end else if (wr_en && idx_reg == `ADCWD_IDX_CTL) begin
            done_reg <= wd[`ADCWD_CTL_DONE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_reg <= 1'b0;
        end else if (conv_end && hit) begin
            win_reg <= 1'b1; // R9 R15
        end else if (wr_en && idx_reg == `ADCWD_IDX_CTL) begin
            win_reg <= wd[`ADCWD_CTL_WIN] & win_reg; // R18
        end
    end

endmodule : adcwd_top
`default_nettype wire

/* adcwd_monitor.sv */
// concurrent checks on the bus and converter ports of the formatter
`timescale 1ns/1ps
`default_nettype none
`include "adcwd_regs.svh"

module adcwd_monitor (
    // clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // converter
    input wire logic conversion_busy
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take;
    logic wr_q;
    logic [9:0] idx_q;
    logic [9:0] run_q;
    assign take = hsel && htrans[1] && hready && hreadyout;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            idx_q <= 10'h000;
        end else if (take) begin
            wr_q <= hwrite;
            idx_q <= haddr[11:2];
        end
    end
    // length of the current busy stretch in clock cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q <= 10'h000;
        end else if (!conversion_busy) begin
            run_q <= 10'h000;
        end else if (run_q != 10'h3ff) begin
            run_q <= run_q + 10'h001;
        end
    end
    sequence s_rd;
        !hreadyout && !wr_q;
    endsequence
    sequence s_ctl_wr;
        !hreadyout && wr_q && idx_q == `ADCWD_IDX_CTL && !conversion_busy;
    endsequence
    // ****************************************************************
    // assertions
    // ****************************************************************
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    wait_state_a: assert property (take |=> !hreadyout ##1 hreadyout)
        else $error("transfer not one wait state");
    ready_cause_a: assert property ($fell(hreadyout) |-> $past(take))
        else $error("wait state without transfer");
    read_upper_a: assert property (s_rd |=> hrdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    unmapped_zero_a: assert property
        (s_rd ##0 (idx_q < `ADCWD_IDX_CFG) |=> hrdata == 32'h00000000)
        else $error("unmapped read not zero");
    busy_start_a: assert property (s_ctl_wr ##0 (hwdata[7] && hwdata[4]
        && hwdata[3:2] == 2'b00) |=> conversion_busy)
        else $error("conversion did not start");
    no_start_a: assert property (s_ctl_wr ##0 !hwdata[7] |=> !conversion_busy)
        else $error("disabled converter started");
    busy_len_a: assert property ($fell(conversion_busy) |-> run_q >= 10'd16)
        else $error("conversion shorter than sixteen clocks");
endmodule : adcwd_monitor

bind adcwd_top adcwd_monitor i_mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .conversion_busy(conversion_busy)
);
`default_nettype wire

/* testbench.sv */
// self-checking bench for the result formatter and window detector
`timescale 1ns/1ps
`default_nettype none
`include "adcwd_regs.svh"

module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic [9:0] sar_code = 10'h000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic conversion_busy;
    logic exp_win = 1'b0;
    int fail_count = 0;
    int n_compared = 0;

    always #5 hclk = ~hclk;

    adcwd_top i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sar_code(sar_code), .conversion_busy(conversion_busy)
    );

    // ****************************************************************
    // bus tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask : chk

    task automatic xfer(input logic [9:0] i, input logic w,
            input logic [7:0] d, output logic [31:0] q);
        logic rdy;
        int n;
        haddr <= {20'h00000, i, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
                @(negedge hclk);
                rdy = hreadyout;
                q = hrdata;
                n++;
                @(posedge hclk);
            end while (rdy !== 1'b1 && n < 20);
            chk({31'h0, rdy}, 32'h1);
            if (p == 0) begin
                htrans <= 2'b00;
                hwdata <= {24'h000000, d};
            end
        end
    endtask : xfer

    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        logic [31:0] q;
        xfer(i, 1'b1, d, q);
    endtask : wr

    task automatic rc(input logic [9:0] i, input logic [7:0] e);
        logic [31:0] q;
        xfer(i, 1'b0, 8'h00, q);
        chk(q, {24'h000000, e});
    endtask : rc

    task automatic run(input logic [9:0] c, input logic lj, input logic df,
            input logic kp, input logic [15:0] gt, input logic [15:0] lt,
            input logic [4:0] sc);
        logic [15:0] w;
        logic hit;
        int n;
        w = lj ? {c, 6'h00} : {{6{c[9] & df}}, c};
        hit = (lt > gt) ? (w < lt && w > gt) : (w < lt || w > gt);
        exp_win = kp ? (exp_win | hit) : hit;
        sar_code <= c;
        wr(`ADCWD_IDX_CFG, {sc, 3'h0});
        wr(`ADCWD_IDX_MODE, {7'h00, df});
        wr(`ADCWD_IDX_GTH, gt[15:8]);
        wr(`ADCWD_IDX_GTL, gt[7:0]);
        wr(`ADCWD_IDX_LTH, lt[15:8]);
        wr(`ADCWD_IDX_LTL, lt[7:0]);
        wr(`ADCWD_IDX_CTL, {6'b100100, kp, lj});
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (conversion_busy === 1'b1 && n < 600);
        @(posedge hclk);
        chk(32'(n), 32'(16 * (sc + 1)));
        rc(`ADCWD_IDX_RESH, w[15:8]);
        rc(`ADCWD_IDX_RESL, w[7:0]);
        rc(`ADCWD_IDX_CTL, {6'b101000, exp_win, lj});
        $display("test conversion %h done", c);
    endtask : run

    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(`ADCWD_IDX_CFG, 8'hf8);
        rc(`ADCWD_IDX_CTL, 8'h00);
        rc(`ADCWD_IDX_MODE, 8'h00);
        rc(`ADCWD_IDX_RESH, 8'h00);
        rc(`ADCWD_IDX_RESL, 8'h00);
        rc(`ADCWD_IDX_GTH, 8'hff);
        rc(`ADCWD_IDX_GTL, 8'hff);
        rc(`ADCWD_IDX_LTH, 8'h00);
        rc(`ADCWD_IDX_LTL, 8'h00);
        wr(10'h001, 8'h5a);
        rc(10'h001, 8'h00);
        wr(`ADCWD_IDX_CTL, 8'h10);
        rc(`ADCWD_IDX_CTL, 8'h00);
        wr(`ADCWD_IDX_CTL, 8'h94);
        rc(`ADCWD_IDX_CTL, 8'h84);
        $display("test reset and refusals done");
        run(10'h3ff, 1'b0, 1'b0, 1'b0, 16'h0100, 16'h0200, 5'h00);
        run(10'h150, 1'b0, 1'b0, 1'b0, 16'h0100, 16'h0200, 5'h00);
        run(10'h3ff, 1'b0, 1'b0, 1'b1, 16'h0100, 16'h0200, 5'h01);
        run(10'h3ff, 1'b1, 1'b0, 1'b0, 16'h0200, 16'h0100, 5'h00);
        run(10'h300, 1'b0, 1'b1, 1'b0, 16'h0100, 16'h0200, 5'h01);
        run(10'h000, 1'b1, 1'b1, 1'b0, 16'hffc0, 16'h4000, 5'h00);
        run(10'h201, 1'b1, 1'b1, 1'b0, 16'h4000, 16'hffc0, 5'h00);
        give_verdict();
    end

    initial begin
        #200000;
        fail_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
